// File: design/tswd_control.sv
// Two-stage watchdog: command decode, period coupling and expiry actions.
`timescale 1ns/1ps
module tswd_control #(
  parameter int TICK_CYCLES = tswd_pkg::TICK_CYCLES
) (
  input  wire logic                   ref_clk,
  input  wire logic                   reset,
  input  wire logic                   link_up,
  input  wire logic                   cmd_valid,
  input  wire tswd_pkg::tswd_cmd_type cmd,
  output logic                        rsp_valid,
  output tswd_pkg::tswd_err_type      rsp_error,
  output tswd_pkg::tswd_status_type   rsp_status,
  output logic                        owned,
  output logic                        warning_pulse,
  output logic                        board_reset,
  output logic [1:0]                  tmr_running
);

  localparam int TICK_W = $clog2(TICK_CYCLES);
  localparam int PW     = tswd_pkg::PERIOD_W;

  // ****************************************************************
  // Tick prescaler
  // ****************************************************************
  logic [TICK_W-1:0] tick_count;
  logic [TICK_W-1:0] next_tick_count;
  logic              tick;
  logic              next_tick;

  // One tick every 0.1 s; the divider never stops so ticks stay even.
  always_comb begin
    next_tick       = (tick_count == TICK_W'(TICK_CYCLES - 1));
    next_tick_count = next_tick ? '0 : tick_count + TICK_W'(1);
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      tick_count <= '0;
      tick       <= 1'b0;
    end else begin
      tick_count <= next_tick_count;
      tick       <= next_tick;
    end
  end

  // ****************************************************************
  // Stage timers
  // ****************************************************************
  logic [1:0]         load;
  logic [1:0]         halt;
  logic [1:0][PW-1:0] load_val;
  logic [1:0][PW-1:0] tmr_count;
  logic [1:0]         expire;

  for (genvar i = 0; i < tswd_pkg::NUM_STAGES; i++) begin : g_stage
    tswd_countdown #(.WIDTH(PW)) u_timer (
      .ref_clk    (ref_clk),
      .reset      (reset),
      .tick       (tick),
      .load       (load[i]),
      .halt       (halt[i]),
      .load_value (load_val[i]),
      .running    (tmr_running[i]),
      .count      (tmr_count[i]),
      .expire     (expire[i])
    );
  end

  // ****************************************************************
  // Helpers
  // ****************************************************************
  // Out-of-range periods fall back to the stage default.
  function automatic logic [PW-1:0] fix_period(input logic [PW-1:0] v,
                                               input logic is_second);
    logic [PW-1:0] dflt;
    dflt = is_second ? tswd_pkg::SECOND_DEFAULT_TICKS
                     : tswd_pkg::FIRST_DEFAULT_TICKS;
    if (v == tswd_pkg::PERIOD_ZERO || v == tswd_pkg::PERIOD_ALL_ONES) begin
      return dflt;
    end
    return v;
  endfunction

  // Stopped, running with action, or running with action suppressed.
  function automatic logic [7:0] stage_status(input logic run,
                                              input logic sup,
                                              input logic exp);
    logic [7:0] s;
    s = run ? (sup ? tswd_pkg::ST_FREERUN : tswd_pkg::ST_RUNNING)
            : tswd_pkg::ST_STOPPED;
    return exp ? (s | tswd_pkg::ST_EXPIRED) : s;
  endfunction

  function automatic logic valid_stage(input logic [7:0] s);
    return s == tswd_pkg::STAGE_FIRST || s == tswd_pkg::STAGE_SECOND;
  endfunction

  // ****************************************************************
  // Control state
  // ****************************************************************
  logic [1:0][PW-1:0]        period;
  logic [1:0][PW-1:0]        next_period;
  logic [1:0][7:0]           follow_sel;
  logic [1:0][7:0]           next_follow_sel;
  logic [1:0][PW-1:0]        follow_period;
  logic [1:0][PW-1:0]        next_follow_period;
  logic [1:0]                suppress;
  logic [1:0]                next_suppress;
  logic [1:0]                expired;
  logic [1:0]                next_expired;
  logic                      next_owned;
  logic                      next_rsp_valid;
  tswd_pkg::tswd_err_type    next_rsp_error;
  tswd_pkg::tswd_status_type next_rsp_status;
  logic                      next_warning;
  logic                      next_board_reset;
  logic                      sidx;
  logic                      oidx;
  logic                      fidx;
  logic [PW-1:0]             arm_p;

  assign sidx = (cmd.stage == tswd_pkg::STAGE_SECOND);
  assign oidx = ~sidx;

  // Expiry actions first, then the command; a command that loads a
  // stage overrides a follow-on load of the same stage in that cycle.
  always_comb begin
    next_period        = period;
    next_follow_sel    = follow_sel;
    next_follow_period = follow_period;
    next_suppress      = suppress;
    next_expired       = expired;
    next_owned         = owned;
    next_rsp_valid     = 1'b0;
    next_rsp_error     = rsp_error;
    next_rsp_status    = rsp_status;
    next_warning       = 1'b0;
    next_board_reset   = 1'b0;
    load               = '0;
    halt               = '0;
    load_val           = period;
    arm_p              = '0;
    fidx               = 1'b0;
    for (int i = 0; i < tswd_pkg::NUM_STAGES; i++) begin
      if (expire[i]) begin
        next_expired[i] = 1'b1;
        if (!suppress[i]) begin
          if (i == tswd_pkg::FIRST_IDX) begin
            next_warning = 1'b1;
          end else begin
            next_board_reset = 1'b1;
          end
        end
        if (follow_sel[i] != tswd_pkg::STAGE_NONE) begin
          fidx              = (follow_sel[i] == tswd_pkg::STAGE_SECOND);
          load[fidx]        = 1'b1;
          load_val[fidx]    = follow_period[i];
          next_period[fidx] = follow_period[i];
        end
      end
    end
    if (cmd_valid) begin
      next_rsp_valid = 1'b1;
      next_rsp_error = tswd_pkg::ERR_NONE;
      if (!link_up) begin
        next_rsp_error = tswd_pkg::ERR_NOT_CONNECTED;
      end else begin
        case (cmd.op)
          tswd_pkg::OP_OPEN: begin
            if (owned) begin
              next_rsp_error = tswd_pkg::ERR_OWNER_CONFLICT;
            end else begin
              next_owned = 1'b1;
            end
          end
          tswd_pkg::OP_CLOSE: begin
            next_owned = 1'b0;
          end
          tswd_pkg::OP_STATUS: begin
            if (!valid_stage(cmd.stage)) begin
              next_rsp_error = tswd_pkg::ERR_INVALID;
            end else begin
              next_rsp_status.first  = stage_status(tmr_running[0],
                                         suppress[0], expired[0]);
              next_rsp_status.second = stage_status(tmr_running[1],
                                         suppress[1], expired[1]);
              // A new expiry in this cycle survives the clear.
              next_expired[sidx] = expire[sidx];
            end
          end
          tswd_pkg::OP_ARM: begin
            if (!valid_stage(cmd.stage) ||
                (cmd.restart != tswd_pkg::STAGE_NONE &&
                 !valid_stage(cmd.restart))) begin
              next_rsp_error = tswd_pkg::ERR_INVALID;
            end else begin
              arm_p             = fix_period(cmd.period, sidx);
              next_period[sidx] = arm_p;
              if (!sidx && tmr_running[1] && arm_p > period[1]) begin
                next_period[1] = arm_p;
              end
              if (sidx && tmr_running[0] && arm_p < period[0]) begin
                next_period[0] = arm_p;
              end
              load[sidx]     = 1'b1;
              load_val[sidx] = arm_p;
              if (tmr_running[oidx]) begin
                load[oidx]     = 1'b1;
                load_val[oidx] = next_period[oidx];
              end
              next_follow_sel[sidx]    = cmd.restart;
              next_follow_period[sidx] = fix_period(cmd.next_period,
                cmd.restart == tswd_pkg::STAGE_SECOND);
              next_suppress[sidx]      = 1'b0;
            end
          end
          tswd_pkg::OP_DISARM: begin
            if (!valid_stage(cmd.stage)) begin
              next_rsp_error = tswd_pkg::ERR_INVALID_DEVICE;
            end else begin
              if (cmd.suppress[tswd_pkg::FIRST_SUPPRESS_POS]) begin
                next_suppress[0] = 1'b1;
                halt[0]          = 1'b1;
              end
              // A started second stage cannot be silenced.
              if (cmd.suppress[tswd_pkg::SECOND_SUPPRESS_POS] &&
                  !tmr_running[1]) begin
                next_suppress[1] = 1'b1;
              end
            end
          end
          default: begin
            next_rsp_error = tswd_pkg::ERR_INVALID;
          end
        endcase
      end
    end
  end

  // Register the control state.
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      period        <= {tswd_pkg::SECOND_DEFAULT_TICKS,
                        tswd_pkg::FIRST_DEFAULT_TICKS};
      follow_sel    <= '0;
      follow_period <= '0;
      suppress      <= '0;
      expired       <= '0;
      owned         <= 1'b0;
      rsp_valid     <= 1'b0;
      rsp_error     <= tswd_pkg::ERR_NONE;
      rsp_status    <= '0;
      warning_pulse <= 1'b0;
      board_reset   <= 1'b0;
    end else begin
      period        <= next_period;
      follow_sel    <= next_follow_sel;
      follow_period <= next_follow_period;
      suppress      <= next_suppress;
      expired       <= next_expired;
      owned         <= next_owned;
      rsp_valid     <= next_rsp_valid;
      rsp_error     <= next_rsp_error;
      rsp_status    <= next_rsp_status;
      warning_pulse <= next_warning;
      board_reset   <= next_board_reset;
    end
  end

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);

  logic lc;
  assign lc = cmd_valid && link_up && !(|expire);

  status_clear_a: assert property (lc && cmd.op == tswd_pkg::OP_STATUS &&
    cmd.stage == tswd_pkg::STAGE_FIRST |=> !expired[0] && rsp_valid &&
    rsp_error == tswd_pkg::ERR_NONE) else $error("expiry flag not cleared");
  arm_other_a: assert property (lc && cmd.op == tswd_pkg::OP_ARM &&
    cmd.stage == tswd_pkg::STAGE_FIRST && cmd.restart == 8'h00 &&
    tmr_running[1] |=> tmr_running[1] && tmr_count[1] == period[1])
    else $error("other stage not restarted");
  order_kept_a: assert property (lc && cmd.op == tswd_pkg::OP_ARM |=>
    !(tmr_running[0] && tmr_running[1]) || period[0] <= period[1])
    else $error("first period exceeds second");
  lower_first_a: assert property (lc && cmd.op == tswd_pkg::OP_ARM &&
    cmd.stage == tswd_pkg::STAGE_SECOND && cmd.restart == 8'h00 &&
    tmr_running[0] && cmd.period != 16'h0000 && cmd.period != 16'hffff &&
    cmd.period < period[0] |=> period[0] == $past(cmd.period) &&
    tmr_count[0] == $past(cmd.period)) else $error("first not lowered");
  raise_second_a: assert property (lc && cmd.op == tswd_pkg::OP_ARM &&
    cmd.stage == tswd_pkg::STAGE_FIRST && cmd.restart == 8'h00 &&
    tmr_running[1] && cmd.period != 16'h0000 && cmd.period != 16'hffff &&
    cmd.period > period[1] |=> period[1] == $past(cmd.period))
    else $error("second not raised");
  stop_first_a: assert property (lc && cmd.op == tswd_pkg::OP_DISARM &&
    valid_stage(cmd.stage) && cmd.suppress[0] |=> !tmr_running[0] &&
    suppress[0] ##1 !warning_pulse) else $error("first stage not stopped");
  stop_second_a: assert property (lc && cmd.op == tswd_pkg::OP_DISARM &&
    cmd.suppress[1] && tmr_running[1] |=> tmr_running[1] && !suppress[1])
    else $error("second stage was stopped");
  bad_stage_a: assert property (lc && cmd.op == tswd_pkg::OP_DISARM &&
    !valid_stage(cmd.stage) |=> rsp_error == tswd_pkg::ERR_INVALID_DEVICE &&
    $stable(suppress) && $stable(period)) else $error("bad stage accepted");
  busy_a: assert property (lc && cmd.op == tswd_pkg::OP_OPEN && owned
    |=> rsp_error == tswd_pkg::ERR_OWNER_CONFLICT && owned)
    else $error("second owner admitted");
  unknown_op_a: assert property (lc && cmd.op > tswd_pkg::OP_STATUS &&
    cmd.op != tswd_pkg::OP_OPEN && cmd.op != tswd_pkg::OP_CLOSE |=>
    rsp_error == tswd_pkg::ERR_INVALID && $stable(period))
    else $error("unknown command accepted");
  bad_restart_a: assert property (lc && cmd.op == tswd_pkg::OP_ARM &&
    cmd.restart > tswd_pkg::STAGE_SECOND |=> rsp_error ==
    tswd_pkg::ERR_INVALID && $stable(follow_sel)) else $error("bad restart");
  no_link_a: assert property (cmd_valid && !link_up |=> rsp_valid &&
    rsp_error == tswd_pkg::ERR_NOT_CONNECTED) else $error("link down ignored");
  default_a: assert property (lc && cmd.op == tswd_pkg::OP_ARM &&
    cmd.stage == tswd_pkg::STAGE_FIRST && cmd.restart == 8'h00 &&
    cmd.period == 16'h0000 |=> period[0] == tswd_pkg::FIRST_DEFAULT_TICKS)
    else $error("default period not loaded");
  follow_on_a: assert property (expire[0] && !cmd_valid &&
    follow_sel[0] == tswd_pkg::STAGE_FIRST |=> tmr_running[0] &&
    tmr_count[0] == $past(follow_period[0])) else $error("no follow-on");
  reset_out_a: assert property (expire[1] && !suppress[1] |=>
    board_reset ##1 !board_reset) else $error("board reset not pulsed");
  tick_gap_a: assert property ($rose(tick) |=> !tick)
    else $error("tick wider than one cycle");

  warn_c: cover property (warning_pulse);
  reset_c: cover property (board_reset);
  busy_c: cover property (rsp_error == tswd_pkg::ERR_OWNER_CONFLICT);
  both_c: cover property (tmr_running == 2'b11);

endmodule

// File: design/tswd_pkg.sv
// Package for the two-stage watchdog: constants, codes and carrier types.
package tswd_pkg;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int CLK_PERIOD_NS     = 5;
  localparam int TICK_TIME_NS      = 100_000_000;
  localparam int TICK_CYCLES       = TICK_TIME_NS / CLK_PERIOD_NS;
  localparam int TICK_TIME_MS      = 100;
  localparam int FIRST_DEFAULT_MS  = 10_000;
  localparam int SECOND_DEFAULT_MS = 15_000;
  localparam int PERIOD_W          = 16;

  localparam logic [PERIOD_W-1:0] FIRST_DEFAULT_TICKS =
    PERIOD_W'(FIRST_DEFAULT_MS / TICK_TIME_MS);
  localparam logic [PERIOD_W-1:0] SECOND_DEFAULT_TICKS =
    PERIOD_W'(SECOND_DEFAULT_MS / TICK_TIME_MS);
  localparam logic [PERIOD_W-1:0] PERIOD_ZERO     = 16'h0000;
  localparam logic [PERIOD_W-1:0] PERIOD_ALL_ONES = 16'hffff;

  // ****************************************************************
  // Command codes, stage selectors and mask bits
  // ****************************************************************
  localparam logic [7:0] OP_ARM    = 8'h00;
  localparam logic [7:0] OP_DISARM = 8'h01;
  localparam logic [7:0] OP_STATUS = 8'h02;
  localparam logic [7:0] OP_OPEN   = 8'h10;
  localparam logic [7:0] OP_CLOSE  = 8'h11;

  localparam logic [7:0] STAGE_NONE   = 8'h00;
  localparam logic [7:0] STAGE_FIRST  = 8'h01;
  localparam logic [7:0] STAGE_SECOND = 8'h02;

  localparam int NUM_STAGES = 2;
  localparam int FIRST_IDX  = 0;
  localparam int SECOND_IDX = 1;

  localparam int FIRST_SUPPRESS_POS  = 0;
  localparam int SECOND_SUPPRESS_POS = 1;

  // Status byte bits of each stage.
  localparam logic [7:0] ST_EXPIRED = 8'h01;
  localparam logic [7:0] ST_FREERUN = 8'h02;
  localparam logic [7:0] ST_RUNNING = 8'h04;
  localparam logic [7:0] ST_STOPPED = 8'h08;

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef enum logic [2:0] {
    ERR_NONE           = 3'h0,
    ERR_OWNER_CONFLICT = 3'h1,
    ERR_BAD_POINTER    = 3'h2,
    ERR_INVALID        = 3'h3,
    ERR_NOT_CONNECTED  = 3'h4,
    ERR_INVALID_DEVICE = 3'h5
  } tswd_err_type;

  typedef struct packed {
    logic [7:0]          op;
    logic [7:0]          stage;
    logic [PERIOD_W-1:0] period;
    logic [7:0]          restart;
    logic [PERIOD_W-1:0] next_period;
    logic [7:0]          suppress;
  } tswd_cmd_type;

  typedef struct packed {
    logic [7:0] second;
    logic [7:0] first;
  } tswd_status_type;

endpackage

// File: design/tswd_countdown.sv
// One countdown timer stage of the two-stage watchdog.
`timescale 1ns/1ps
module tswd_countdown #(
  parameter int WIDTH = tswd_pkg::PERIOD_W
) (
  input  wire logic             ref_clk,
  input  wire logic             reset,
  input  wire logic             tick,
  input  wire logic             load,
  input  wire logic             halt,
  input  wire logic [WIDTH-1:0] load_value,
  output logic                  running,
  output logic [WIDTH-1:0]      count,
  output logic                  expire
);

  logic             next_running;
  logic [WIDTH-1:0] next_count;
  logic             next_expire;

  // ****************************************************************
  // Count down one step per tick; a load beats halt and restarts an expiring stage, but that expiry still pulses expire.
  // ****************************************************************
  always_comb begin
    next_running = running;
    next_count   = count;
    next_expire  = 1'b0;
    if (running && tick) begin
      if (count <= WIDTH'(1)) begin
        next_count   = '0;
        next_running = 1'b0;
        next_expire  = 1'b1; // Single-cycle event.
      end else begin
        next_count = count - WIDTH'(1);
      end
    end
    // A halted stage must not report an expiry in the same cycle, or a
    // stop could still fire a follow-on load.
    if (halt) begin
      next_running = 1'b0;
      next_expire  = 1'b0;
    end
    if (load) begin
      next_count   = load_value;
      next_running = 1'b1;
    end
  end

  // Register the timer state.
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      running <= 1'b0;
      count   <= '0;
      expire  <= 1'b0;
    end else begin
      running <= next_running;
      count   <= next_count;
      expire  <= next_expire;
    end
  end

endmodule

// File: sim/tswd_host_model.sv
// Host-side command source for the two-stage watchdog bench.
`timescale 1ns/1ps
module tswd_host_model (
  input  wire logic             ref_clk,
  output logic                  cmd_valid,
  output tswd_pkg::tswd_cmd_type cmd
);
  // Idle at time zero so the first edge sees no request.
  initial begin
    cmd_valid = 1'b0;
    cmd       = '0;
  end

  // One request per call, raised and dropped at falling edges.
  // The fields are scrambled after release so stale values never match.
  task automatic send(input tswd_pkg::tswd_cmd_type c);
    @(negedge ref_clk);
    cmd_valid = 1'b1;
    cmd       = c;
    @(negedge ref_clk);
    cmd_valid = 1'b0;
    cmd       = ~c;
  endtask
endmodule

// File: sim/tb_two_stage_watchdog_control.sv
// Self-checking bench for the two-stage watchdog control block.
`timescale 1ns/1ps
module tb_two_stage_watchdog_control;
  localparam int T = 8;
  typedef struct packed {
    logic                      chk;
    tswd_pkg::tswd_err_type    err;
    tswd_pkg::tswd_status_type st;
  } tswd_note_type;

  logic ref_clk, reset, link_up, cmd_valid, rsp_valid, owned;
  logic warning_pulse, board_reset;
  logic [1:0] tmr_running;
  logic [31:0] seed;
  tswd_pkg::tswd_cmd_type cmd;
  tswd_pkg::tswd_err_type rsp_error;
  tswd_pkg::tswd_status_type rsp_status;
  tswd_note_type notes[$];
  int error_cnt, samples_checked, per;

  tswd_host_model u_host (.ref_clk(ref_clk), .cmd_valid(cmd_valid),
    .cmd(cmd));
  tswd_control #(.TICK_CYCLES(T)) DUT (.ref_clk(ref_clk), .reset(reset),
    .link_up(link_up), .cmd_valid(cmd_valid), .cmd(cmd),
    .rsp_valid(rsp_valid), .rsp_error(rsp_error), .rsp_status(rsp_status),
    .owned(owned), .warning_pulse(warning_pulse),
    .board_reset(board_reset), .tmr_running(tmr_running));

  // Free-running 200 MHz clock.
  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end

  task automatic fail(input string m);
    error_cnt++;
    $display("CHECK FAILED %0t: %s", $time, m);
  endtask

  task automatic give_verdict();
    $display("errors %0d, checks %0d", error_cnt, samples_checked);
    if (error_cnt == 0 && samples_checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  // Note the expected answer first, then issue the request.
  task automatic req(input logic [7:0] op, stg, input logic [15:0] p,
                     input logic [7:0] rs, sup, input tswd_note_type e);
    notes.push_back(e);
    u_host.send({op, stg, p, rs, 16'h0000, sup});
  endtask

  // Bounded wait for a warning or a board reset, in cycles.
  task automatic wait_evt(input bit rst, input int lo, input int hi);
    int n;
    n = 0;
    while (n <= hi && (rst ? board_reset : warning_pulse) !== 1'b1) begin
      @(negedge ref_clk);
      n++;
    end
    samples_checked++;
    if (n > hi) begin
      fail("expiry never came");
      give_verdict();
    end
    if (n < lo) fail("expiry came early");
  endtask

  // Responses are compared against the oldest note when they show up.
  always @(negedge ref_clk) begin
    if (rsp_valid === 1'b1) begin
      samples_checked++;
      if (notes.size() == 0) fail("unexpected response");
      else if (rsp_error !== notes[0].err ||
               (notes[0].chk && rsp_status !== notes[0].st))
        fail("response mismatch");
      if (notes.size() != 0) void'(notes.pop_front());
    end
  end

  initial begin
    reset   = 1'b1;
    link_up = 1'b0;
    seed    = 32'h2739;
    repeat (10) @(negedge ref_clk);
    reset = 1'b0;
    req(8'h02, 8'h01, 0, 0, 0, {1'b0, tswd_pkg::ERR_NOT_CONNECTED, 16'h0});
    link_up = 1'b1;
    req(8'h10, 0, 0, 0, 0, {1'b0, tswd_pkg::ERR_NONE, 16'h0});
    req(8'h10, 0, 0, 0, 0, {1'b0, tswd_pkg::ERR_OWNER_CONFLICT, 16'h0});
    req(8'h55, 8'h01, 5, 0, 0, {1'b0, tswd_pkg::ERR_INVALID, 16'h0});
    req(8'h00, 8'h01, 5, 8'h03, 0, {1'b0, tswd_pkg::ERR_INVALID, 16'h0});
    req(8'h01, 8'h00, 0, 0, 8'h01, {1'b0, tswd_pkg::ERR_INVALID_DEVICE, 16'h0});
    req(8'h02, 8'h03, 0, 0, 0, {1'b0, tswd_pkg::ERR_INVALID, 16'h0});
    if (tmr_running !== 2'b00 || owned !== 1'b1) fail("state changed");
    // Zero and all ones both load the 100 tick default.
    for (int i = 0; i < 2; i++) begin
      req(8'h00, 8'h01, i ? 16'hffff : 16'h0, 0, 0, {1'b0, tswd_pkg::ERR_NONE, 16'h0});
      wait_evt(1'b0, 99 * T, 101 * T + 4);
    end
    per = 2 + ($unsigned($random(seed)) % 4);
    req(8'h00, 8'h01, per[15:0], 0, 0, {1'b0, tswd_pkg::ERR_NONE, 16'h0});
    wait_evt(1'b0, (per - 1) * T, (per + 1) * T + 4);
    req(8'h02, 8'h01, 0, 0, 0, {1'b1, tswd_pkg::ERR_NONE, 8'h08, 8'h09});
    req(8'h02, 8'h01, 0, 0, 0, {1'b1, tswd_pkg::ERR_NONE, 8'h08, 8'h08});
    // Second armed short, then first armed longer drags second up.
    req(8'h00, 8'h02, 2, 0, 0, {1'b0, tswd_pkg::ERR_NONE, 16'h0});
    req(8'h00, 8'h01, 6, 0, 0, {1'b0, tswd_pkg::ERR_NONE, 16'h0});
    req(8'h01, 8'h02, 0, 0, 8'h02, {1'b0, tswd_pkg::ERR_NONE, 16'h0});
    req(8'h01, 8'h01, 0, 0, 8'h01, {1'b0, tswd_pkg::ERR_NONE, 16'h0});
    samples_checked++;
    if (tmr_running !== 2'b10) fail("wrong timers running");
    wait_evt(1'b1, 4 * T, 7 * T + 8);
    req(8'h02, 8'h02, 0, 0, 0, {1'b1, tswd_pkg::ERR_NONE, 8'h09, 8'h08});
    repeat (4) @(negedge ref_clk);
    give_verdict();
  end
endmodule
